// ==== design/fqb_query.sv ====
// Query table section reporting page size, burst lengths and partition layout.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "fqb_cfg.svh"

module fqb_query
(
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire fqb_pkg::fqb_addr_t addr_i,
   input  wire fqb_pkg::fqb_data_t wdata_i,
   input  wire logic            wr_i,
   input  wire logic            rd_i,
   output      fqb_pkg::fqb_data_t rdata_o,
   output      logic            query_mode_o
);
   import fqb_pkg::*;

   fqb_state_t state;
   fqb_state_t next_state;

   logic [7:0] table_byte;
   logic       table_hit;
   logic       regions_present;
   logic       page_capable;
   logic       burst_capable;
   logic       cont_capable;
   logic [7:0] status_byte;

   // A literal cannot be part-selected, so the partition count is held here and split into bytes.
   localparam logic [15:0] PART_COUNT = `FQB_VAL_PART_COUNT;

   // With no partition regions nothing follows the count byte, so the region fields read as zero.
   assign regions_present = (`FQB_VAL_REGION_COUNT != 8'h00);
   assign page_capable    = (`FQB_VAL_PAGE_SIZE != 8'h00);
   assign burst_capable   = (`FQB_VAL_SYNC_COUNT != 8'h00);
   assign cont_capable    = burst_capable && ((`FQB_VAL_SYNC_CAP4 & `FQB_CAP_CODE_MASK) == {5'h00, `FQB_VAL_CONTINUOUS});

   always_comb
   begin
      table_byte = 8'h00;
      table_hit  = 1'b1;
      unique case (addr_i)
         `FQB_ADDR_WIDTH_CODE:   table_byte = `FQB_VAL_WIDTH_CODE;
         `FQB_ADDR_PAGE_SIZE:    table_byte = `FQB_VAL_PAGE_SIZE;
         `FQB_ADDR_SYNC_COUNT:   table_byte = `FQB_VAL_SYNC_COUNT;
         // Only the code bits are driven so the reserved bits can be copied straight into configuration.
         `FQB_ADDR_SYNC_CAP1:    table_byte = `FQB_VAL_SYNC_CAP1 & `FQB_CAP_CODE_MASK;
         `FQB_ADDR_SYNC_CAP2:    table_byte = `FQB_VAL_SYNC_CAP2 & `FQB_CAP_CODE_MASK;
         `FQB_ADDR_SYNC_CAP3:    table_byte = `FQB_VAL_SYNC_CAP3 & `FQB_CAP_CODE_MASK;
         `FQB_ADDR_SYNC_CAP4:    table_byte = `FQB_VAL_SYNC_CAP4 & `FQB_CAP_CODE_MASK;
         `FQB_ADDR_REGION_COUNT: table_byte = `FQB_VAL_REGION_COUNT;
         `FQB_ADDR_PART_LO:      table_byte = regions_present ? PART_COUNT[7:0] : 8'h00;
         `FQB_ADDR_PART_HI:      table_byte = regions_present ? PART_COUNT[15:8] : 8'h00;
         `FQB_ADDR_OPS_WITHIN:   table_byte = regions_present ? `FQB_VAL_OPS_WITHIN : 8'h00;
         `FQB_ADDR_OPS_PROGRAM:  table_byte = regions_present ? `FQB_VAL_OPS_PROGRAM : 8'h00;
         `FQB_ADDR_OPS_ERASE:    table_byte = regions_present ? `FQB_VAL_OPS_ERASE : 8'h00;
         default:                table_hit  = 1'b0;
      endcase
   end

   always_comb
   begin
      status_byte = 8'h00;
      status_byte[`FQB_STAT_QUERY_BIT] = state.query_mode;
      status_byte[`FQB_STAT_UNMAP_BIT] = state.unmapped;
      status_byte[`FQB_STAT_PAGE_BIT]  = page_capable;
      status_byte[`FQB_STAT_BURST_BIT] = burst_capable;
      status_byte[`FQB_STAT_CONT_BIT]  = cont_capable;
   end

   always_comb
   begin
      next_state       = state;
      next_state.rdata = 16'h0000;
      if (wr_i && (addr_i == `FQB_ADDR_CTRL))
      begin
         next_state.query_mode = wdata_i[`FQB_CTRL_QUERY_BIT];
         if (wdata_i[`FQB_CTRL_CLEAR_BIT])
         begin
            next_state.unmapped = 1'b0;
         end
      end
      if (rd_i)
      begin
         if (addr_i == `FQB_ADDR_CTRL)
         begin
            next_state.rdata = {15'h0000, state.query_mode};
         end
         else if (addr_i == `FQB_ADDR_STATUS)
         begin
            next_state.rdata = {8'h00, status_byte};
         end
         else if (table_hit)
         begin
            // Outside query mode the table is hidden and reads as zero.
            next_state.rdata = state.query_mode ? {8'h00, table_byte} : 16'h0000;
         end
         else
         begin
            // A new miss wins over a clear written in the same cycle.
            next_state.unmapped = 1'b1;
         end
      end
      if (wr_i && (addr_i != `FQB_ADDR_CTRL))
      begin
         next_state.unmapped = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state.rdata      <= `FQB_RST_RDATA;
         state.query_mode <= `FQB_RST_QUERY_MODE;
         state.unmapped   <= `FQB_RST_UNMAPPED;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign rdata_o      = state.rdata;
   assign query_mode_o = state.query_mode;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_query_read(logic [7:0] a);
      rd_i && state.query_mode && (addr_i == a);
   endsequence

   a_page_size_code: assert property (s_query_read(8'h4c) |=> rdata_o == 16'h0003)
      else $error("page size code wrong");
   a_width_code: assert property (s_query_read(8'h28) |=> rdata_o == 16'h0001)
      else $error("word width code wrong");
   a_sync_count: assert property (s_query_read(8'h4d) |=> rdata_o == 16'h0004)
      else $error("sync count wrong");
   a_cap_walk: assert property (s_query_read(8'h4e) ##1 s_query_read(8'h4f) |=>
      rdata_o == 16'h0002 && $past(rdata_o) == 16'h0001)
      else $error("capability bytes out of order");
   a_cap_cont: assert property (s_query_read(8'h51) |=> rdata_o == 16'h0007 && $past(state.query_mode))
      else $error("continuous burst code wrong");
   a_cap_reserved: assert property (rd_i && addr_i >= 8'h4e && addr_i <= 8'h51 |=> rdata_o[15:3] == 13'h0000)
      else $error("reserved capability bits set");
   a_upper_zero: assert property (rd_i && state.query_mode && addr_i < 8'hf0 |=> rdata_o[15:8] == 8'h00)
      else $error("upper byte not zero");
   a_read_one_cycle: assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("read data outlived its cycle");
   a_part_count: assert property (s_query_read(8'h53) ##1 s_query_read(8'h54) |=>
      {rdata_o[7:0], $past(rdata_o[7:0])} == 16'h0001)
      else $error("partition count wrong");
   a_ops_nibbles: assert property (s_query_read(8'h55) |=> rdata_o == 16'h0011)
      else $error("within partition ops wrong");
   a_ops_beside: assert property (s_query_read(8'h56) or s_query_read(8'h57) |=> rdata_o == 16'h0000)
      else $error("beside ops wrong");
   a_region_count: assert property (s_query_read(8'h52) |=> rdata_o == 16'h0001)
      else $error("region count wrong");
   a_capable_flags: assert property (rd_i && addr_i == 8'hf1 |=> rdata_o[3:2] == 2'b11)
      else $error("capability flags wrong");
   a_unmapped_set: assert property (rd_i && !table_hit && addr_i != 8'hf0 && addr_i != 8'hf1 |=> state.unmapped)
      else $error("unmapped read not flagged");

endmodule

// ==== design/fqb_cfg.svh ====
// Address map, table contents and reset values of the query burst and partition table.
`ifndef FQB_CFG_SVH
`define FQB_CFG_SVH

`define FQB_ADDR_WIDTH_CODE   8'h28
`define FQB_ADDR_PAGE_SIZE    8'h4c
`define FQB_ADDR_SYNC_COUNT   8'h4d
`define FQB_ADDR_SYNC_CAP1    8'h4e
`define FQB_ADDR_SYNC_CAP2    8'h4f
`define FQB_ADDR_SYNC_CAP3    8'h50
`define FQB_ADDR_SYNC_CAP4    8'h51
`define FQB_ADDR_REGION_COUNT 8'h52
`define FQB_ADDR_PART_LO      8'h53
`define FQB_ADDR_PART_HI      8'h54
`define FQB_ADDR_OPS_WITHIN   8'h55
`define FQB_ADDR_OPS_PROGRAM  8'h56
`define FQB_ADDR_OPS_ERASE    8'h57
`define FQB_ADDR_CTRL         8'hf0
`define FQB_ADDR_STATUS       8'hf1

`define FQB_VAL_WIDTH_CODE    8'h01
`define FQB_VAL_PAGE_SIZE     8'h03
`define FQB_VAL_SYNC_COUNT    8'h04
`define FQB_VAL_SYNC_CAP1     8'h01
`define FQB_VAL_SYNC_CAP2     8'h02
`define FQB_VAL_SYNC_CAP3     8'h03
`define FQB_VAL_SYNC_CAP4     8'h07
`define FQB_VAL_CONTINUOUS    3'h7
`define FQB_VAL_REGION_COUNT  8'h01
`define FQB_VAL_PART_COUNT    16'h0001
`define FQB_VAL_OPS_WITHIN    8'h11
`define FQB_VAL_OPS_PROGRAM   8'h00
`define FQB_VAL_OPS_ERASE     8'h00

`define FQB_CAP_CODE_MASK     8'h07
`define FQB_CTRL_QUERY_BIT    0
`define FQB_CTRL_CLEAR_BIT    1
`define FQB_STAT_QUERY_BIT    0
`define FQB_STAT_UNMAP_BIT    1
`define FQB_STAT_PAGE_BIT     2
`define FQB_STAT_BURST_BIT    3
`define FQB_STAT_CONT_BIT     4
`define FQB_RST_QUERY_MODE    1'b1
`define FQB_RST_UNMAPPED      1'b0
`define FQB_RST_RDATA         16'h0000

`endif

// ==== design/fqb_pkg.sv ====
// Types shared by the query burst and partition table.
package fqb_pkg;

   typedef logic [7:0]  fqb_addr_t;
   typedef logic [15:0] fqb_data_t;

   typedef struct packed
   {
      fqb_data_t rdata;
      logic      query_mode;
      logic      unmapped;
   } fqb_state_t;

endpackage

// ==== verification/fqb_host_model.sv ====
// Host model that reads the query table over the register bus.
`timescale 1ns/1ps
module fqb_host_model
(
   input  wire logic               clk_i,
   input  wire fqb_pkg::fqb_data_t rdata_i,
   output      fqb_pkg::fqb_addr_t addr_o,
   output      fqb_pkg::fqb_data_t wdata_o,
   output      logic               wr_o,
   output      logic               rd_o
);
   import fqb_pkg::*;
   logic [2:0] read_cfg = 3'h0;
   logic       page_ok  = 1'b0;
   logic       burst_ok = 1'b0;
   initial
   begin
      addr_o  = 8'h00;
      wdata_o = 16'h0000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // Released bus lines show the inverse of the last value.
   task automatic rd(input fqb_addr_t a, output fqb_data_t d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      #1 d = rdata_i;
   endtask
   // Two reads with no gap between the strobes; each answer is taken in the cycle where it stands.
   task automatic rd_pair(input fqb_addr_t a0, input fqb_addr_t a1, output fqb_data_t d0, output fqb_data_t d1);
      @(posedge clk_i);
      addr_o <= a0;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      addr_o <= a1;
      #1 d0 = rdata_i;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a1;
      #1 d1 = rdata_i;
   endtask
   task automatic wr(input fqb_addr_t a, input fqb_data_t dt);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= dt;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~dt;
      #1;
   endtask
   task automatic learn();
      fqb_data_t d;
      rd(8'h28, d);
      rd(8'h4c, d);
      page_ok = (d[7:0] != 8'h00);
      rd(8'h4d, d);
      burst_ok = (d[7:0] != 8'h00);
      rd(8'h51, d);
      if (burst_ok)
         read_cfg = d[2:0];
   endtask
endmodule

// ==== verification/fqb_query_tb_top.sv ====
// Self-checking testbench of the query burst and partition table.
`timescale 1ns/1ps
module fqb_query_tb_top;
   import fqb_pkg::*;
   logic      clk_i = 1'b0;
   logic      rst_i = 1'b1;
   fqb_addr_t addr;
   fqb_data_t wdata;
   fqb_data_t rdata;
   logic      wr;
   logic      rd;
   logic      qmode;
   int        n_fail = 0;
   int        cmp_count = 0;
   int        cycles = 0;
   always #2 clk_i = ~clk_i;
   fqb_query uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
                  .rdata_o(rdata), .query_mode_o(qmode));
   fqb_host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   task automatic give_verdict();
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic chk(input fqb_data_t got, input fqb_data_t exp);
      cmp_count++;
      if (got !== exp)
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      if (got !== exp)
         n_fail++;
   endtask
   task automatic t_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 chk({15'h0, qmode}, 16'h0001);
      chk(rdata, 16'h0000);
   endtask
   task automatic t_table();
      fqb_addr_t a [13] = '{8'h28, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57};
      fqb_data_t e [13] = '{16'h01, 16'h03, 16'h04, 16'h01, 16'h02, 16'h03, 16'h07, 16'h01, 16'h01, 16'h00,
                            16'h11, 16'h00, 16'h00};
      fqb_data_t d;
      for (int i = 0; i < 13; i++)
      begin
         host.rd(a[i], d);
         chk(d, e[i]);
         if (a[i] inside {[8'h4e:8'h51]})
            chk(d & 16'hfff8, 16'h0000);
      end
      @(posedge clk_i);
      #1 chk(rdata, 16'h0000);
   endtask
   task automatic t_learn();
      host.learn();
      chk({14'h0, host.page_ok, host.burst_ok}, 16'h0003);
      chk({13'h0, host.read_cfg}, 16'h0007);
   endtask
   task automatic t_pairs();
      fqb_data_t d0;
      fqb_data_t d1;
      host.rd_pair(8'h4e, 8'h4f, d0, d1);
      chk(d0, 16'h0001);
      chk(d1, 16'h0002);
      host.rd_pair(8'h53, 8'h54, d0, d1);
      chk({d1[7:0], d0[7:0]}, 16'h0001);
      chk({d1[15:8], d0[15:8]}, 16'h0000);
   endtask
   task automatic t_unmapped();
      fqb_data_t d;
      host.rd(8'hf1, d);
      chk(d, 16'h001d);
      host.wr(8'h30, 16'h00ff);
      host.rd(8'hf1, d);
      chk(d, 16'h001f);
      host.wr(8'hf0, 16'h0003);
      host.rd(8'h99, d);
      chk(d, 16'h0000);
      host.rd(8'hf1, d);
      chk(d, 16'h001f);
      host.wr(8'hf0, 16'h0003);
      host.rd(8'hf1, d);
      chk(d, 16'h001d);
   endtask
   task automatic t_query_off();
      fqb_data_t d;
      host.wr(8'hf0, 16'h0000);
      chk({15'h0, qmode}, 16'h0000);
      host.rd(8'h4c, d);
      chk(d, 16'h0000);
      host.rd(8'hf0, d);
      chk(d, 16'h0000);
      host.rd(8'hf1, d);
      chk(d, 16'h001c);
   endtask
   initial
   begin
      t_reset();
      t_table();
      t_learn();
      t_pairs();
      t_unmapped();
      t_query_off();
      t_reset();
      t_table();
      give_verdict();
   end
endmodule
